// File: design/touch_scan_pkg.sv
package touch_scan_pkg;

  // ----------------------------------------------------------------------
  // Register map: word index, byte address is the index times four.
  // ----------------------------------------------------------------------
  localparam int unsigned IDX_WIDTH       = 3;
  localparam int unsigned ADDR_LSB        = 2;
  localparam logic [2:0]  IDX_CONTROL     = 3'h0;
  localparam logic [2:0]  IDX_TIMING      = 3'h1;
  localparam logic [2:0]  IDX_CURRENT     = 3'h2;
  localparam logic [2:0]  IDX_CHANNEL     = 3'h3;
  localparam logic [2:0]  IDX_RESULT_HIGH = 3'h6;
  localparam logic [2:0]  IDX_RESULT_LOW  = 3'h7;

  // ----------------------------------------------------------------------
  // Control register bits.
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_ENABLE      = 0;
  localparam int unsigned BIT_STOP_ENABLE = 1;
  localparam int unsigned BIT_TRIG_MODE   = 2;
  localparam int unsigned BIT_IRQ_ENABLE  = 3;
  localparam int unsigned BIT_SW_TRIGGER  = 4;
  localparam int unsigned BIT_ACTIVE      = 5;
  localparam int unsigned BIT_DONE        = 6;

  // ----------------------------------------------------------------------
  // Field positions and widths.
  // ----------------------------------------------------------------------
  localparam int unsigned SCAN_COUNT_LSB  = 0;
  localparam int unsigned SCAN_COUNT_W    = 5;
  localparam int unsigned PRESCALE_LSB    = 5;
  localparam int unsigned PRESCALE_W      = 3;
  localparam int unsigned REF_CUR_LSB     = 0;
  localparam int unsigned ELEC_CUR_LSB    = 4;
  localparam int unsigned CURRENT_W       = 3;
  localparam int unsigned CHANNEL_LSB     = 0;
  localparam int unsigned CHANNEL_W       = 4;
  localparam int unsigned RESULT_W        = 16;
  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned MODULUS_W       = 6;
  localparam int unsigned DIVIDER_W       = 7;

  // ----------------------------------------------------------------------
  // Synchroniser lanes for inputs from outside the clock domain.
  // ----------------------------------------------------------------------
  localparam int unsigned SYNC_WIDTH      = 3;
  localparam int unsigned LANE_ELECTRODE  = 0;
  localparam int unsigned LANE_REFERENCE  = 1;
  localparam int unsigned LANE_HW_TRIGGER = 2;

  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

  typedef enum logic {
    state_idle,
    state_scan
  } scan_state_type;

  typedef struct packed {
    logic [2:0] reference_current_sel;
    logic [2:0] electrode_current_sel;
    logic [3:0] channel_select;
  } analog_ctrl_type;

endpackage

// File: design/input_sync.sv
`timescale 1ns/1ps
`default_nettype none

module input_sync (
  // Clock and reset.
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [touch_scan_pkg::SYNC_WIDTH-1:0] async_in,
  output logic      [touch_scan_pkg::SYNC_WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [touch_scan_pkg::SYNC_WIDTH-1:0] first;
    logic [touch_scan_pkg::SYNC_WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type cur;
  sync_state_type next_cur;

  // The first stage feeds only the second stage.
  always_comb begin
    next_cur        = cur;
    next_cur.first  = async_in;
    next_cur.second = cur.first;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.second;

endmodule
`default_nettype wire

// File: design/osc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module osc_prescaler (
  // Clock and reset.
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // Control.
  input  wire logic                                  clear,
  input  wire logic [touch_scan_pkg::PRESCALE_W-1:0] osc_prescale_sel,
  // Electrode edges in, prescaled ticks out.
  input  wire logic                                  edge_in,
  output logic                                       tick
);

  typedef struct packed {
    logic [touch_scan_pkg::DIVIDER_W-1:0] count;
    logic                                 tick;
  } divider_state_type;

  divider_state_type                    cur;
  divider_state_type                    next_cur;
  logic [touch_scan_pkg::DIVIDER_W-1:0] terminal;

  // Divide ratio is two to the power of the selection, 1 up to 128.
  always_comb begin
    terminal      = touch_scan_pkg::DIVIDER_W'((8'h01 << osc_prescale_sel)
                    - 8'h01);
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (clear) begin
      next_cur.count = '0;
    end else if (edge_in) begin
      if (cur.count == terminal) begin
        next_cur.count = '0;
        next_cur.tick  = 1'b1;
      end else begin
        next_cur.count = cur.count + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;

endmodule
`default_nettype wire

// File: design/capacitive_touch_scan_counter.sv
`timescale 1ns/1ps
`default_nettype none

module capacitive_touch_scan_counter (
  // Clock and reset.
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave.
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // Oscillators and chip events.
  input  wire logic                          electrode_osc,
  input  wire logic                          reference_osc,
  input  wire logic                          hw_trigger,
  input  wire logic                          chip_in_stop3,
  // Status and analog control.
  output logic                               scan_irq,
  output logic                               scan_active_flag,
  output touch_scan_pkg::analog_ctrl_type    analog_ctrl
);

  // ----------------------------------------------------------------------
  // State record.
  // ----------------------------------------------------------------------
  typedef struct packed {
    touch_scan_pkg::scan_state_type                  state;
    logic                                            sensing_enable_bit;
    logic                                            stop_mode_enable_bit;
    logic                                            trigger_mode_sel;
    logic                                            scan_irq_enable;
    logic [touch_scan_pkg::SCAN_COUNT_W-1:0]         scan_count_sel;
    logic [touch_scan_pkg::PRESCALE_W-1:0]           osc_prescale_sel;
    touch_scan_pkg::analog_ctrl_type                 analog;
    logic                                            active_flag;
    logic                                            done_flag;
    logic                                            irq;
    logic [touch_scan_pkg::MODULUS_W-1:0]            modulus;
    logic [touch_scan_pkg::RESULT_W-1:0]             ref_count;
    logic [touch_scan_pkg::RESULT_W-1:0]             result;
    logic                                            electrode_prev;
    logic                                            reference_prev;
    logic                                            trigger_prev;
    logic                                            dp_valid;
    logic                                            dp_write;
    logic [touch_scan_pkg::IDX_WIDTH-1:0]            dp_idx;
    logic [31:0]                                     rdata;
    logic                                            ready;
  } unit_state_type;

  unit_state_type                           cur;
  unit_state_type                           next_cur;
  logic [touch_scan_pkg::SYNC_WIDTH-1:0]    sync_in;
  logic [touch_scan_pkg::SYNC_WIDTH-1:0]    synced;
  logic                                     electrode_edge;
  logic                                     reference_edge;
  logic                                     trigger_edge;
  logic                                     running;
  logic                                     start;
  logic                                     sw_start;
  logic                                     presc_tick;
  logic [touch_scan_pkg::MODULUS_W-1:0]     modulus_limit;
  logic [touch_scan_pkg::IDX_WIDTH-1:0]     addr_idx;
  logic [touch_scan_pkg::RESULT_W-1:0]      ref_next;

  // ----------------------------------------------------------------------
  // Synchronisers and prescaler.
  // ----------------------------------------------------------------------
  always_comb begin
    sync_in                                  = '0;
    sync_in[touch_scan_pkg::LANE_ELECTRODE]  = electrode_osc;
    sync_in[touch_scan_pkg::LANE_REFERENCE]  = reference_osc;
    sync_in[touch_scan_pkg::LANE_HW_TRIGGER] = hw_trigger;
  end

  input_sync u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (sync_in),
    .sync_out (synced)
  );

  osc_prescaler u_prescaler (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .clear            (start),
    .osc_prescale_sel (cur.osc_prescale_sel),
    .edge_in          (electrode_edge),
    .tick             (presc_tick)
  );

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur       = cur;
    sw_start       = 1'b0;
    start          = 1'b0;
    ref_next       = '0;
    addr_idx       = haddr[touch_scan_pkg::ADDR_LSB +:
                           touch_scan_pkg::IDX_WIDTH];
    // Stop3 halts the unit unless stop operation is allowed.
    running        = cur.sensing_enable_bit &&
                     (!chip_in_stop3 || cur.stop_mode_enable_bit);
    electrode_edge = running && (cur.state == touch_scan_pkg::state_scan) &&
                     synced[touch_scan_pkg::LANE_ELECTRODE] &&
                     !cur.electrode_prev;
    reference_edge = synced[touch_scan_pkg::LANE_REFERENCE] &&
                     !cur.reference_prev;
    trigger_edge   = synced[touch_scan_pkg::LANE_HW_TRIGGER] &&
                     !cur.trigger_prev;
    // A field of zero gives one scan, the top value gives 32.
    modulus_limit  = touch_scan_pkg::MODULUS_W'(cur.scan_count_sel) +
                     touch_scan_pkg::MODULUS_W'(1);
    next_cur.electrode_prev = synced[touch_scan_pkg::LANE_ELECTRODE];
    next_cur.reference_prev = synced[touch_scan_pkg::LANE_REFERENCE];
    next_cur.trigger_prev   = synced[touch_scan_pkg::LANE_HW_TRIGGER];
    next_cur.ready          = 1'b1;

    // Data phase of a write updates the registers.
    if (cur.dp_valid && cur.dp_write) begin
      if (cur.dp_idx == touch_scan_pkg::IDX_CONTROL) begin
        next_cur.sensing_enable_bit   = hwdata[touch_scan_pkg::BIT_ENABLE];
        next_cur.stop_mode_enable_bit =
          hwdata[touch_scan_pkg::BIT_STOP_ENABLE];
        next_cur.trigger_mode_sel     = hwdata[touch_scan_pkg::BIT_TRIG_MODE];
        next_cur.scan_irq_enable      = hwdata[touch_scan_pkg::BIT_IRQ_ENABLE];
        sw_start = hwdata[touch_scan_pkg::BIT_SW_TRIGGER];
        if (hwdata[touch_scan_pkg::BIT_DONE]) begin
          next_cur.done_flag = 1'b0;
        end
      end else if (cur.dp_idx == touch_scan_pkg::IDX_TIMING) begin
        next_cur.scan_count_sel   = hwdata[touch_scan_pkg::SCAN_COUNT_LSB +:
                                           touch_scan_pkg::SCAN_COUNT_W];
        next_cur.osc_prescale_sel = hwdata[touch_scan_pkg::PRESCALE_LSB +:
                                           touch_scan_pkg::PRESCALE_W];
      end else if (cur.dp_idx == touch_scan_pkg::IDX_CURRENT) begin
        next_cur.analog.reference_current_sel =
          hwdata[touch_scan_pkg::REF_CUR_LSB +: touch_scan_pkg::CURRENT_W];
        next_cur.analog.electrode_current_sel =
          hwdata[touch_scan_pkg::ELEC_CUR_LSB +: touch_scan_pkg::CURRENT_W];
      end else if (cur.dp_idx == touch_scan_pkg::IDX_CHANNEL) begin
        next_cur.analog.channel_select =
          hwdata[touch_scan_pkg::CHANNEL_LSB +: touch_scan_pkg::CHANNEL_W];
      end
    end

    // Trigger selection; a trigger during a scan is ignored.
    // The settings of a write landing this cycle already apply, so one
    // control write may enable the unit and trigger it together.
    start = next_cur.sensing_enable_bit &&
            (cur.state == touch_scan_pkg::state_idle) &&
            (next_cur.trigger_mode_sel ? trigger_edge
                                       : sw_start);

    case (cur.state)
      touch_scan_pkg::state_idle: begin
        if (start) begin
          next_cur.state       = touch_scan_pkg::state_scan;
          next_cur.active_flag = 1'b1;
          next_cur.modulus     = '0;
          next_cur.ref_count   = '0;
        end
      end
      touch_scan_pkg::state_scan: begin
        if (!next_cur.sensing_enable_bit) begin
          next_cur.state       = touch_scan_pkg::state_idle;
          next_cur.active_flag = 1'b0;
        end else if (running) begin
          ref_next = cur.ref_count +
                     touch_scan_pkg::RESULT_W'(reference_edge);
          next_cur.ref_count = ref_next;
          if (presc_tick) begin
            if (cur.modulus + touch_scan_pkg::MODULUS_W'(1) ==
                modulus_limit) begin
              // Final scan done: the sum over all scans becomes visible.
              next_cur.result      = ref_next;
              next_cur.done_flag   = 1'b1;
              next_cur.active_flag = 1'b0;
              next_cur.state       = touch_scan_pkg::state_idle;
            end else begin
              next_cur.modulus = cur.modulus +
                                 touch_scan_pkg::MODULUS_W'(1);
            end
          end
        end
      end
      default: begin
        next_cur.state = touch_scan_pkg::state_idle;
      end
    endcase

    next_cur.irq = next_cur.done_flag && next_cur.scan_irq_enable;

    // Address phase; read data reflect any write landing this cycle.
    next_cur.dp_valid = hsel && hready &&
                        (htrans == touch_scan_pkg::HTRANS_NONSEQ);
    next_cur.dp_write = hwrite;
    next_cur.dp_idx   = addr_idx;
    next_cur.rdata    = '0;
    if (next_cur.dp_valid && !hwrite) begin
      if (addr_idx == touch_scan_pkg::IDX_CONTROL) begin
        next_cur.rdata[touch_scan_pkg::BIT_ENABLE]      =
          next_cur.sensing_enable_bit;
        next_cur.rdata[touch_scan_pkg::BIT_STOP_ENABLE] =
          next_cur.stop_mode_enable_bit;
        next_cur.rdata[touch_scan_pkg::BIT_TRIG_MODE]   =
          next_cur.trigger_mode_sel;
        next_cur.rdata[touch_scan_pkg::BIT_IRQ_ENABLE]  =
          next_cur.scan_irq_enable;
        next_cur.rdata[touch_scan_pkg::BIT_ACTIVE]      = next_cur.active_flag;
        next_cur.rdata[touch_scan_pkg::BIT_DONE]        = next_cur.done_flag;
      end else if (addr_idx == touch_scan_pkg::IDX_TIMING) begin
        next_cur.rdata[touch_scan_pkg::SCAN_COUNT_LSB +:
                       touch_scan_pkg::SCAN_COUNT_W] = next_cur.scan_count_sel;
        next_cur.rdata[touch_scan_pkg::PRESCALE_LSB +:
                       touch_scan_pkg::PRESCALE_W] = next_cur.osc_prescale_sel;
      end else if (addr_idx == touch_scan_pkg::IDX_CURRENT) begin
        next_cur.rdata[touch_scan_pkg::REF_CUR_LSB +:
                       touch_scan_pkg::CURRENT_W] =
          next_cur.analog.reference_current_sel;
        next_cur.rdata[touch_scan_pkg::ELEC_CUR_LSB +:
                       touch_scan_pkg::CURRENT_W] =
          next_cur.analog.electrode_current_sel;
      end else if (addr_idx == touch_scan_pkg::IDX_CHANNEL) begin
        next_cur.rdata[touch_scan_pkg::CHANNEL_LSB +:
                       touch_scan_pkg::CHANNEL_W] =
          next_cur.analog.channel_select;
      end else if (addr_idx == touch_scan_pkg::IDX_RESULT_HIGH) begin
        next_cur.rdata[touch_scan_pkg::BYTE_W-1:0] =
          next_cur.result[touch_scan_pkg::RESULT_W-1:
                          touch_scan_pkg::BYTE_W];
      end else if (addr_idx == touch_scan_pkg::IDX_RESULT_LOW) begin
        next_cur.rdata[touch_scan_pkg::BYTE_W-1:0] =
          next_cur.result[touch_scan_pkg::BYTE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur       <= '0;
      cur.ready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign hrdata           = cur.rdata;
  assign hreadyout        = cur.ready;
  assign hresp            = 1'b0;
  assign scan_irq         = cur.irq;
  assign scan_active_flag = cur.active_flag;
  assign analog_ctrl      = cur.analog;

endmodule
`default_nettype wire

// File: dv/touch_scan_properties.sv
`timescale 1ns/1ps
`default_nettype none

module touch_scan_properties (
  // Clock and reset.
  input wire logic                            hclk,
  input wire logic                            hresetn,
  // Bus.
  input wire logic                            hsel,
  input wire logic [31:0]                     haddr,
  input wire logic [1:0]                      htrans,
  input wire logic                            hwrite,
  input wire logic [31:0]                     hwdata,
  input wire logic                            hready,
  input wire logic [31:0]                     hrdata,
  input wire logic                            hreadyout,
  input wire logic                            hresp,
  // Status and analog control.
  input wire logic                            scan_irq,
  input wire logic                            scan_active_flag,
  input wire touch_scan_pkg::analog_ctrl_type analog_ctrl
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       wr_q;
  logic       rd_res_q;
  logic [2:0] wr_idx;
  logic       take;

  assign take = hsel && hready && htrans == touch_scan_pkg::HTRANS_NONSEQ;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      rd_res_q <= 1'b0;
      wr_idx   <= 3'h0;
    end else begin
      wr_q     <= take && hwrite;
      rd_res_q <= take && !hwrite && haddr[4:3] == 2'h3;
      wr_idx   <= haddr[4:2];
    end
  end

  sequence s_wr(logic [2:0] idx); wr_q && hready && wr_idx == idx; endsequence

  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not ready or not okay");
  property p_current; s_wr(touch_scan_pkg::IDX_CURRENT) |=>
    analog_ctrl[9:4] == {$past(hwdata[2:0]), $past(hwdata[6:4])}; endproperty
  a_current: assert property (p_current)
    else $error("current selections not routed");
  property p_channel; s_wr(touch_scan_pkg::IDX_CHANNEL) |=>
    analog_ctrl.channel_select == $past(hwdata[3:0]); endproperty
  a_channel: assert property (p_channel)
    else $error("channel select not routed");
  property p_sw_start; s_wr(touch_scan_pkg::IDX_CONTROL) ##0
    (hwdata[4:0] & 5'h15) == 5'h11 && !scan_active_flag |=> scan_active_flag;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("software trigger did not start a scan");
  property p_hw_hold; s_wr(touch_scan_pkg::IDX_CONTROL) ##0
    hwdata[2] && !scan_active_flag |=> !scan_active_flag; endproperty
  a_hw_hold: assert property (p_hw_hold)
    else $error("scan started without hardware trigger");
  property p_disable; s_wr(touch_scan_pkg::IDX_CONTROL) ##0 !hwdata[0]
    |=> !scan_active_flag; endproperty
  a_disable: assert property (p_disable)
    else $error("scan active while disabled");
  property p_irq_end; $rose(scan_irq) |-> $fell(scan_active_flag); endproperty
  a_irq_end: assert property (p_irq_end)
    else $error("interrupt not at scan end");
  property p_result_byte; rd_res_q |-> hrdata[31:8] == 24'h0; endproperty
  a_result_byte: assert property (p_result_byte)
    else $error("result register wider than a byte");
endmodule

bind capacitive_touch_scan_counter
  touch_scan_properties u_touch_scan_properties (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .scan_irq(scan_irq), .scan_active_flag(scan_active_flag),
  .analog_ctrl(analog_ctrl));

`default_nettype wire

// File: dv/osc_model.sv
`timescale 1ns/1ps
`default_nettype none

module osc_model #(
  parameter int ELEC_HALF = 16,
  parameter int REF_HALF  = 4
) (
  // Clock and scan frame.
  input  wire logic hclk,
  input  wire logic run,
  // Oscillator outputs.
  // One electrode only: it toggles while a scan runs and is held low otherwise.
  output logic      electrode_osc,
  output logic      reference_osc
);
  int elec_count;
  int ref_count;

  // Both stand low outside a scan and restart in phase, so the count is known.
  always @(posedge hclk) begin
    if (!run) begin
      elec_count    <= 0;
      ref_count     <= 0;
      electrode_osc <= 1'b0;
      reference_osc <= 1'b0;
    end else begin
      elec_count <= (elec_count == ELEC_HALF - 1) ? 0 : elec_count + 1;
      ref_count  <= (ref_count == REF_HALF - 1) ? 0 : ref_count + 1;
      if (elec_count == ELEC_HALF - 1) electrode_osc <= ~electrode_osc;
      if (ref_count == REF_HALF - 1) reference_osc <= ~reference_osc;
    end
  end
endmodule

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                            hclk = 1'b0;
  logic                            hresetn = 1'b0;
  logic                            hsel = 1'b0;
  logic                            hwrite = 1'b0;
  logic                            hw_trigger = 1'b0;
  logic                            chip_in_stop3 = 1'b0;
  logic [1:0]                      htrans = 2'h0;
  logic [31:0]                     haddr = 32'h0;
  logic [31:0]                     hwdata = 32'h0;
  logic [31:0]                     hrdata;
  logic [31:0]                     rd;
  logic                            hreadyout;
  logic                            hresp;
  logic                            scan_irq;
  logic                            scan_active_flag;
  logic                            electrode_osc;
  logic                            reference_osc;
  touch_scan_pkg::analog_ctrl_type analog_ctrl;
  int                              errors = 0;
  int                              check_count = 0;
  int                              cycles = 0;

  capacitive_touch_scan_counter u_capacitive_touch_scan_counter (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .electrode_osc(electrode_osc),
    .reference_osc(reference_osc), .hw_trigger(hw_trigger),
    .chip_in_stop3(chip_in_stop3), .scan_irq(scan_irq),
    .scan_active_flag(scan_active_flag), .analog_ctrl(analog_ctrl));

  osc_model u_osc_model (.hclk(hclk), .run(scan_active_flag),
    .electrode_osc(electrode_osc), .reference_osc(reference_osc));

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [2:0] idx,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    hwrite <= wr;
    haddr  <= {27'h0, idx, 2'h0};
    htrans <= touch_scan_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Runs one sequence and checks the count against the reference ratio of 4.
  task automatic run_scan(input logic [7:0] tmg, input logic [31:0] ctrl);
    int          i;
    int          m;
    logic [15:0] res;
    m = (tmg[4:0] + 1) << tmg[7:5];
    bus(1'b1, touch_scan_pkg::IDX_TIMING, {24'h0, tmg});
    bus(1'b1, touch_scan_pkg::IDX_CONTROL, ctrl);
    for (i = 0; i < 5000 && rd[6] !== 1'b1; i++)
      bus(1'b0, touch_scan_pkg::IDX_CONTROL, 32'h0);
    check("active", {31'h0, scan_active_flag}, 32'h0);
    check("irq", {31'h0, scan_irq}, {31'h0, ctrl[3]});
    bus(1'b0, touch_scan_pkg::IDX_RESULT_HIGH, 32'h0);
    res[15:8] = rd[7:0];
    bus(1'b0, touch_scan_pkg::IDX_RESULT_LOW, 32'h0);
    res[7:0] = rd[7:0];
    check("result", {31'h0, res >= 4 * m - 4 && res <= 4 * m}, 1);
    bus(1'b1, touch_scan_pkg::IDX_CONTROL, (ctrl & 32'h0F) | 32'h40);
    repeat (2) @(posedge hclk);
    check("irq clear", {31'h0, scan_irq}, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge hclk);
    check("reset bus", {hreadyout, hresp}, 2'h2);
    hresetn <= 1'b1;
    bus(1'b0, touch_scan_pkg::IDX_CONTROL, 32'h0);
    check("control reset", rd, 32'h0);
    bus(1'b0, touch_scan_pkg::IDX_RESULT_LOW, 32'h0);
    check("result reset", rd, 32'h0);
    bus(1'b1, touch_scan_pkg::IDX_CURRENT, 32'h53);
    bus(1'b1, touch_scan_pkg::IDX_CHANNEL, 32'hA);
    repeat (2) @(posedge hclk);
    check("analog", analog_ctrl, 10'b011_101_1010);
    bus(1'b1, 3'h4, 32'hFFFF_FFFF);
    bus(1'b0, 3'h4, 32'h0);
    check("unmapped", rd, 32'h0);
    run_scan(8'h00, 32'h19);
    run_scan(8'h43, 32'h19);
    run_scan(8'hE1, 32'h19);
    chip_in_stop3 <= 1'b1;
    run_scan(8'h01, 32'h1B);
    bus(1'b1, touch_scan_pkg::IDX_TIMING, 32'h0);
    bus(1'b1, touch_scan_pkg::IDX_CONTROL, 32'h11);
    repeat (100) @(posedge hclk);
    check("stop3 pause", {31'h0, scan_active_flag}, 32'h1);
    chip_in_stop3 <= 1'b0;
    repeat (100) @(posedge hclk);
    check("stop3 resume", {31'h0, scan_active_flag}, 32'h0);
    bus(1'b1, touch_scan_pkg::IDX_TIMING, 32'hE1);
    bus(1'b1, touch_scan_pkg::IDX_CONTROL, 32'h11);
    repeat (50) @(posedge hclk);
    bus(1'b1, touch_scan_pkg::IDX_CONTROL, 32'h40);
    bus(1'b0, touch_scan_pkg::IDX_CONTROL, 32'h0);
    check("abort", rd, 32'h0);
    bus(1'b1, touch_scan_pkg::IDX_TIMING, 32'h0);
    bus(1'b1, touch_scan_pkg::IDX_CONTROL, 32'h15);
    repeat (20) @(posedge hclk);
    check("hw hold", {31'h0, scan_active_flag}, 32'h0);
    hw_trigger <= 1'b1;
    repeat (8) @(posedge hclk);
    check("hw start", {31'h0, scan_active_flag}, 32'h1);
    hw_trigger <= 1'b0;
    repeat (200) @(posedge hclk);
    bus(1'b0, touch_scan_pkg::IDX_CONTROL, 32'h0);
    check("hw done", rd[6:5], 2'h2);
    end_of_test();
  end
endmodule

`default_nettype wire
